// File: rtl/cic_collector.sv
// interrupt collector: pins, bus-written interrupt register, masking, apb registers
// assumes an apb master on sys_clk and a system bus agent that holds each cycle
// for at least three sys_clk periods; the system bus is only ever observed
module cic_collector
   import cic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic nmi_pin_n,
   input wire logic [CIC_INT_PINS-1:0] ext_int_n,
   input wire logic timer_irq,
   input wire logic timer_source_select,
   input wire logic [CIC_AD_W-1:0] sys_addr_data_bus,
   input wire logic [CIC_CMD_W-1:0] sys_command_bus,
   input wire logic sys_data_valid_n,
   input wire logic pipe_advance,
   input wire logic [CIC_APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CIC_AD_W-1:0] pwdata,
   output logic [CIC_AD_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cpu_int_req,
   output logic nmi_redirect,
   output logic irq
);
   typedef struct packed {
      cic_apb_t apb;
      logic ready;
      logic slverr;
      logic [CIC_AD_W-1:0] rdata;
      logic [CIC_IREG_W-1:0] ireg;
      logic [CIC_SW_W-1:0] sw_pend;
      logic [CIC_PEND_W-1:0] mask;
      logic ie;
      logic exception_level_bit;
      logic error_level_bit;
      logic wr_seen;
      logic nmi_lvl_q;
      logic nmi_pend;
      logic redirect;
      logic int_req;
      logic [CIC_EVT_W-1:0] evt;
      logic [CIC_EVT_W-1:0] evt_mask;
      logic irq;
   } cic_top_st_t;

   cic_top_st_t st_r;
   cic_top_st_t st_nxt;
   cic_pin_if pins ();

   logic [CIC_PEND_W-1:0] pend;
   logic nmi_lvl;
   logic nmi_rise;
   logic nmi_any;
   logic bus_wr;
   logic wr_edge;
   logic apb_setup;
   logic apb_write;
   logic req_nxt;
   logic [CIC_EVT_W-1:0] evt_set;

   // bus-written bits: enable lines pick which register bits take the new level
   function automatic logic [CIC_IREG_W-1:0] cic_merge_ireg(
      input logic [CIC_IREG_W-1:0] cur,
      input logic [CIC_AD_W-1:0] ad
   );
      logic [CIC_IREG_W-1:0] res;
      res = cur;
      for (int i = 0; i < CIC_IREG_W; i++) begin
         if (ad[CIC_WE_LSB + i]) begin
            res[i] = ~ad[i];
         end
      end
      return res;
   endfunction : cic_merge_ireg

   ////////////////////////////////////////////////////////////////////////////////
   // pins pass the synchroniser; nothing here drives the system bus
   cic_pin_sync u_sync (
      .sys_clk (sys_clk),
      .rst (rst),
      .nmi_pin_n (nmi_pin_n),
      .ext_int_n (ext_int_n),
      .timer_irq (timer_irq),
      .timer_source_select (timer_source_select),
      .sys_data_valid_n (sys_data_valid_n),
      .sys_command_bus (sys_command_bus),
      .sys_addr_data_bus (sys_addr_data_bus),
      .pins (pins)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // resolved pending field, readable as cause bits 15 to 8
   always_comb begin
      pend = '0;
      pend[CIC_SW_W-1:0] = st_r.sw_pend;
      pend[CIC_PEND_EXT_LSB +: CIC_EXT_DIRECT] =
         st_r.ireg[CIC_EXT_DIRECT-1:0] | ~pins.int_n[CIC_EXT_DIRECT-1:0];
      if (pins.tsel) begin
         pend[CIC_PEND_TOP] = st_r.ireg[CIC_IREG_SHARED] | ~pins.int_n[CIC_IREG_SHARED];
      end else begin
         pend[CIC_PEND_TOP] = pins.timer;
      end
   end

   // non-maskable level ignores every mask and enable
   assign nmi_lvl = st_r.ireg[CIC_IREG_NMI] | ~pins.nmi_n;
   assign nmi_rise = nmi_lvl & ~st_r.nmi_lvl_q;
   assign nmi_any = st_r.nmi_pend | nmi_rise;

   // enables only count in a valid data cycle, once per cycle
   assign bus_wr = ~pins.valid_n & pins.cmd[CIC_CMD_DATA_BIT];
   assign wr_edge = bus_wr & ~st_r.wr_seen;

   // maskable request gated by enable and both level bits
   assign req_nxt = (|(pend & st_r.mask)) & st_r.ie & ~st_r.exception_level_bit & ~st_r.error_level_bit;

   // apb phases: read data latched in setup, write lands at the completing edge
   assign apb_setup = psel & ~penable & (st_r.apb == CIC_APB_IDLE);
   assign apb_write = psel & penable & pwrite & (st_r.apb == CIC_APB_RESP);

   assign evt_set[CIC_EVT_NMI] = nmi_any & pipe_advance;
   assign evt_set[CIC_EVT_REQ] = req_nxt & ~st_r.int_req;
   assign evt_set[CIC_EVT_BUSWR] = wr_edge;

   ////////////////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      st_nxt = st_r;
      st_nxt.wr_seen = bus_wr;
      st_nxt.nmi_lvl_q = nmi_lvl;
      st_nxt.int_req = req_nxt;
      // a stalled pipeline holds the request until it moves again
      st_nxt.redirect = nmi_any & pipe_advance;
      st_nxt.nmi_pend = nmi_any & ~pipe_advance;
      if (wr_edge) begin
         st_nxt.ireg = cic_merge_ireg(st_r.ireg, pins.ad);
      end
      // apb slave
      case (st_r.apb)
         CIC_APB_IDLE: begin
            st_nxt.ready = 1'b0;
            if (apb_setup) begin
               st_nxt.apb = CIC_APB_RESP;
               st_nxt.ready = 1'b1;
               st_nxt.slverr = 1'b0;
               st_nxt.rdata = '0;
               if (paddr == CIC_OFS_STATUS) begin
                  st_nxt.rdata[CIC_ST_MASK_LSB +: CIC_PEND_W] = st_r.mask;
                  st_nxt.rdata[CIC_ST_IE] = st_r.ie;
                  st_nxt.rdata[CIC_ST_EXL] = st_r.exception_level_bit;
                  st_nxt.rdata[CIC_ST_ERL] = st_r.error_level_bit;
               end else if (paddr == CIC_OFS_CAUSE) begin
                  st_nxt.rdata[CIC_CAUSE_PEND_LSB +: CIC_PEND_W] = pend;
               end else if (paddr == CIC_OFS_IREG) begin
                  st_nxt.rdata[CIC_IREG_W-1:0] = st_r.ireg;
               end else if (paddr == CIC_OFS_EVT) begin
                  st_nxt.rdata[CIC_EVT_W-1:0] = st_r.evt;
               end else if (paddr == CIC_OFS_EVT_MASK) begin
                  st_nxt.rdata[CIC_EVT_W-1:0] = st_r.evt_mask;
               end else if (paddr == CIC_OFS_LIVE) begin
                  st_nxt.rdata[CIC_LIVE_NMI] = nmi_lvl;
                  st_nxt.rdata[CIC_LIVE_REQ] = st_r.int_req;
               end else begin
                  st_nxt.slverr = 1'b1;
               end
            end
         end
         CIC_APB_RESP: begin
            st_nxt.ready = 1'b1;
            if (psel & penable) begin
               st_nxt.apb = CIC_APB_IDLE;
               st_nxt.ready = 1'b0;
               st_nxt.slverr = 1'b0;
            end
         end
         default: begin
            st_nxt.apb = CIC_APB_IDLE;
            st_nxt.ready = 1'b0;
         end
      endcase
      // register writes; unmapped writes only raise the error
      if (apb_write) begin
         if (paddr == CIC_OFS_STATUS) begin
            st_nxt.mask = pwdata[CIC_ST_MASK_LSB +: CIC_PEND_W];
            st_nxt.ie = pwdata[CIC_ST_IE];
            st_nxt.exception_level_bit = pwdata[CIC_ST_EXL];
            st_nxt.error_level_bit = pwdata[CIC_ST_ERL];
         end else if (paddr == CIC_OFS_CAUSE) begin
            st_nxt.sw_pend = pwdata[CIC_CAUSE_PEND_LSB +: CIC_SW_W];
         end else if (paddr == CIC_OFS_EVT_MASK) begin
            st_nxt.evt_mask = pwdata[CIC_EVT_W-1:0];
         end
      end
      // sticky events: a new event in the clearing cycle survives the clear
      if (apb_write && paddr == CIC_OFS_EVT) begin
         st_nxt.evt = (st_r.evt & ~pwdata[CIC_EVT_W-1:0]) | evt_set;
      end else begin
         st_nxt.evt = st_r.evt | evt_set;
      end
      st_nxt.irq = |(st_nxt.evt & st_nxt.evt_mask);
   end

   // one register for all state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.apb <= CIC_APB_IDLE;
         st_r.ireg <= CIC_IREG_RST;
         st_r.mask <= CIC_MASK_RST;
         st_r.evt <= CIC_EVT_RST;
         st_r.evt_mask <= CIC_EVT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.slverr;
   assign cpu_int_req = st_r.int_req;
   assign nmi_redirect = st_r.redirect;
   assign irq = st_r.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the collector's own behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   nmi_redirect_a: assert property (
      (nmi_rise && pipe_advance) |=> nmi_redirect)
      else $error("non-maskable edge while advancing gave no redirect");

   nmi_stall_a: assert property (
      !pipe_advance |=> !nmi_redirect ##0 (st_r.nmi_pend == $past(nmi_any)))
      else $error("non-maskable request taken or lost during a stall");

   nmi_unmasked_a: assert property (
      (st_r.ireg[CIC_IREG_NMI] && !st_r.nmi_lvl_q && !st_r.ie) |=> (st_r.nmi_pend || nmi_redirect))
      else $error("bus-written non-maskable bit was suppressed");

   bus_nmi_a: assert property (
      (wr_edge && pins.ad[CIC_WE_LSB + CIC_IREG_NMI])
         |=> (st_r.ireg[CIC_IREG_NMI] == !$past(pins.ad[CIC_IREG_NMI])))
      else $error("line 22 did not write interrupt register bit 6");

   ireg_hold_a: assert property (
      !(bus_wr && !st_r.wr_seen) |=> $stable(st_r.ireg))
      else $error("interrupt register changed outside a data cycle write");

   data_cycle_a: assert property (
      !pins.cmd[CIC_CMD_DATA_BIT] |=> $stable(st_r.ireg))
      else $error("interrupt register written in an address cycle");

   sw_pend_a: assert property (
      !(apb_write && paddr == CIC_OFS_CAUSE) |=> $stable(st_r.sw_pend))
      else $error("software pending bits moved without a software write");

   ext_pin_a: assert property (
      !pins.int_n[0] |-> pend[CIC_PEND_EXT_LSB])
      else $error("external pin 0 did not raise pending bit 10");

   ireg_or_a: assert property (
      st_r.ireg[CIC_EXT_DIRECT-1] |-> pend[CIC_PEND_TOP-1])
      else $error("interrupt register bit 4 did not reach pending bit 14");

   top_sel_a: assert property (
      (pins.tsel && !pins.int_n[CIC_IREG_SHARED] && !pins.timer) |-> pend[CIC_PEND_TOP])
      else $error("pin 5 path not selected for pending bit 15");

   timer_sel_a: assert property (
      !pins.tsel |-> (pend[CIC_PEND_TOP] == pins.timer))
      else $error("timer not selected for pending bit 15");

   req_cause_a: assert property (
      cpu_int_req |-> $past(|(pend & st_r.mask)))
      else $error("maskable request without an unmasked pending bit");

   req_enable_a: assert property (
      (!st_r.ie ##1 !st_r.ie) |-> !cpu_int_req)
      else $error("maskable request while globally disabled");

   req_level_a: assert property (
      (st_r.exception_level_bit || st_r.error_level_bit) |=> !cpu_int_req)
      else $error("maskable request during exception or error level");

   cause_read_a: assert property (
      (apb_setup && !pwrite && paddr == CIC_OFS_CAUSE)
         |=> (prdata[CIC_CAUSE_PEND_LSB +: CIC_PEND_W] == $past(pend)) && pready)
      else $error("cause read did not return the resolved sources");

   ireg_reset_a: assert property (
      @(posedge sys_clk) disable iff (1'b0) rst |=> (st_r.ireg == CIC_IREG_RST))
      else $error("interrupt register not cleared by reset");

   redirect_once_a: assert property (
      (nmi_redirect && !nmi_rise) |=> !nmi_redirect)
      else $error("redirect repeated without a new edge");

   redirect_adv_a: assert property (
      nmi_redirect |-> $past(pipe_advance))
      else $error("redirect taken during a stall");

   pend_drop_a: assert property (
      pipe_advance |=> !st_r.nmi_pend)
      else $error("non-maskable request held while advancing");

   nmi_pin_a: assert property (
      (!pins.nmi_n && !st_r.nmi_lvl_q) |=> (st_r.nmi_pend || nmi_redirect))
      else $error("non-maskable pin was suppressed");

   ireg_bit0_a: assert property (
      (wr_edge && pins.ad[CIC_WE_LSB]) |=> (st_r.ireg[0] == !$past(pins.ad[0])))
      else $error("line 16 did not write register bit 0");

   ireg_keep_a: assert property (
      (wr_edge && !pins.ad[CIC_WE_LSB]) |=> $stable(st_r.ireg[0]))
      else $error("register bit 0 changed without its enable");

   ireg_bit5_a: assert property (
      (wr_edge && pins.ad[CIC_WE_LSB + CIC_IREG_SHARED])
         |=> (st_r.ireg[CIC_IREG_SHARED] == !$past(pins.ad[CIC_IREG_SHARED])))
      else $error("line 21 did not write register bit 5");

   valid_gate_a: assert property (
      pins.valid_n |=> $stable(st_r.ireg))
      else $error("register written without valid data");

   ireg0_pend_a: assert property (
      st_r.ireg[0] |-> pend[CIC_PEND_EXT_LSB])
      else $error("register bit 0 did not reach pending bit 10");

   top_ireg_a: assert property (
      (pins.tsel && st_r.ireg[CIC_IREG_SHARED]) |-> pend[CIC_PEND_TOP])
      else $error("register bit 5 not selected for pending bit 15");

   req_raise_a: assert property (
      (st_r.ie && !st_r.exception_level_bit && !st_r.error_level_bit && (|(pend & st_r.mask))) |=> cpu_int_req)
      else $error("enabled pending source gave no request");

   sw_write_a: assert property (
      (apb_write && paddr == CIC_OFS_CAUSE)
         |=> (st_r.sw_pend == $past(pwdata[CIC_CAUSE_PEND_LSB +: CIC_SW_W])))
      else $error("software write did not set pending bits 1 and 0");
endmodule : cic_collector

// File: common/cic_pkg.sv
// constants, field positions, reset values and types of the cpu interrupt collector
// assumes a single 250 MHz sys_clk domain; pins come from outside and are synchronised
// Behaviour
// - non-maskable pin is sampled into flops on the clock before any use
// - a taken non-maskable request redirects execution to the reset vector
// - in a bus data cycle line 22 enables writing register bit 6 from line 6
// - non-maskable level is register bit 6 or inverted pin, never masked
// - non-maskable request is only taken while the pipeline advances
// - external pins 0 to 5 set pending bits 10 to 15 in order
// - bit 15 takes the pin 5 path when select high, else the timer
// - lines 22 to 16 enable writes of register bits 6 to 0, any subset
// - register bits 4 to 0 or pins 4 to 0 drive pending bits 14 to 10
// - pending bits 1 and 0 change only by software writes
// - pending bits and-ed with mask bits, the eight products or-ed
// - maskable request is that or-term and-ed with the global enable
// - exception level and error level bits also gate the maskable request
// - a selected timer interrupt sets cause bit 15
// - software reads all eight resolved sources from cause bits 15 to 8
// - the device never drives the system bus for an interrupt
// - command bit 4 high marks a data cycle; enables sampled only then
package cic_pkg;
   // system bus and pins
   localparam int CIC_AD_W = 32;
   localparam int CIC_CMD_W = 5;
   localparam int CIC_INT_PINS = 6;
   localparam int CIC_CMD_DATA_BIT = 4;
   localparam int CIC_PIN_W = 1 + CIC_INT_PINS + 1 + 1 + 1 + CIC_CMD_W + CIC_AD_W;
   localparam logic [CIC_PIN_W-1:0] CIC_PIN_IDLE = {1'h1, 6'h3F, 1'h0, 1'h0, 1'h1, 5'h00, 32'h0000_0000};
   // interrupt register and pending field
   localparam int CIC_IREG_W = 7;
   localparam int CIC_WE_LSB = 16;
   localparam int CIC_IREG_NMI = 6;
   localparam int CIC_IREG_SHARED = 5;
   localparam int CIC_EXT_DIRECT = 5;
   localparam int CIC_PEND_W = 8;
   localparam int CIC_SW_W = 2;
   localparam int CIC_PEND_EXT_LSB = 2;
   localparam int CIC_PEND_TOP = 7;
   localparam logic [CIC_IREG_W-1:0] CIC_IREG_RST = 7'h00;
   // status and cause field positions
   localparam int CIC_ST_IE = 0;
   localparam int CIC_ST_EXL = 1;
   localparam int CIC_ST_ERL = 2;
   localparam int CIC_ST_MASK_LSB = 8;
   localparam int CIC_CAUSE_PEND_LSB = 8;
   // apb register map, byte addresses
   localparam int CIC_APB_AW = 12;
   localparam logic [CIC_APB_AW-1:0] CIC_OFS_STATUS = 12'h000;
   localparam logic [CIC_APB_AW-1:0] CIC_OFS_CAUSE = 12'h004;
   localparam logic [CIC_APB_AW-1:0] CIC_OFS_IREG = 12'h008;
   localparam logic [CIC_APB_AW-1:0] CIC_OFS_EVT = 12'h00C;
   localparam logic [CIC_APB_AW-1:0] CIC_OFS_EVT_MASK = 12'h010;
   localparam logic [CIC_APB_AW-1:0] CIC_OFS_LIVE = 12'h014;
   // event status bits
   localparam int CIC_EVT_W = 3;
   localparam int CIC_EVT_NMI = 0;
   localparam int CIC_EVT_REQ = 1;
   localparam int CIC_EVT_BUSWR = 2;
   localparam int CIC_LIVE_NMI = 0;
   localparam int CIC_LIVE_REQ = 1;
   localparam logic [CIC_EVT_W-1:0] CIC_EVT_RST = 3'h0;
   localparam logic [CIC_PEND_W-1:0] CIC_MASK_RST = 8'h00;
   // apb slave phase
   typedef enum logic [0:0] {
      CIC_APB_IDLE = 1'b0,
      CIC_APB_RESP = 1'b1
   } cic_apb_t;
endpackage : cic_pkg

// File: common/cic_pin_if.sv
// synchronised pin bundle passed from the pin synchroniser to the collector
// assumes both ends run on sys_clk
interface cic_pin_if;
   import cic_pkg::*;
   logic nmi_n;
   logic [CIC_INT_PINS-1:0] int_n;
   logic timer;
   logic tsel;
   logic valid_n;
   logic [CIC_CMD_W-1:0] cmd;
   logic [CIC_AD_W-1:0] ad;
   modport src (output nmi_n, output int_n, output timer, output tsel, output valid_n, output cmd, output ad);
   modport dst (input nmi_n, input int_n, input timer, input tsel, input valid_n, input cmd, input ad);
endinterface : cic_pin_if

// File: rtl/cic_pin_sync.sv
// three-flop synchroniser for every pin of the interrupt collector
// assumes pins are asynchronous to sys_clk and hold each bus cycle for several clocks
module cic_pin_sync
   import cic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic nmi_pin_n,
   input wire logic [CIC_INT_PINS-1:0] ext_int_n,
   input wire logic timer_irq,
   input wire logic timer_source_select,
   input wire logic sys_data_valid_n,
   input wire logic [CIC_CMD_W-1:0] sys_command_bus,
   input wire logic [CIC_AD_W-1:0] sys_addr_data_bus,
   cic_pin_if.src pins
);
   typedef struct packed {
      logic [CIC_PIN_W-1:0] s1;
      logic [CIC_PIN_W-1:0] s2;
      logic [CIC_PIN_W-1:0] s3;
      logic [CIC_PIN_W-1:0] stable;
   } cic_sync_st_t;

   cic_sync_st_t st_r;
   cic_sync_st_t st_nxt;
   logic [CIC_PIN_W-1:0] raw;

   ////////////////////////////////////////////////////////////////////////////////
   // whole bundle agrees at once so bus lines and command never mix two cycles
   assign raw = {nmi_pin_n, ext_int_n, timer_irq, timer_source_select, sys_data_valid_n,
                 sys_command_bus, sys_addr_data_bus};

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = raw;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.stable = st_r.s3;
      end
   end

   // idle value keeps active-low pins inactive through reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= {CIC_PIN_IDLE, CIC_PIN_IDLE, CIC_PIN_IDLE, CIC_PIN_IDLE};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign {pins.nmi_n, pins.int_n, pins.timer, pins.tsel, pins.valid_n, pins.cmd, pins.ad} = st_r.stable;

   ////////////////////////////////////////////////////////////////////////////////
   // a disagreeing pair must never reach the filtered value
   sync_hold_a: assert property (
      @(posedge sys_clk) disable iff (rst) (st_r.s2 != st_r.s3) |=> $stable(st_r.stable))
      else $error("synchroniser output moved while stages disagreed");
endmodule : cic_pin_sync

// File: verif/cic_sys_agent.sv
// behavioural system bus agent issuing external single writes to the interrupt register
// assumes sys_clk from the bench; holds every cycle four clocks so the synchroniser sees it
module cic_sys_agent
   import cic_pkg::*;
(
   input wire logic sys_clk,
   output logic [CIC_AD_W-1:0] sys_addr_data_bus,
   output logic [CIC_CMD_W-1:0] sys_command_bus,
   output logic sys_data_valid_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle until the first request
   initial begin
      sys_addr_data_bus = 32'h0000_0000;
      sys_command_bus = 5'h00;
      sys_data_valid_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // address cycle then data cycle; enables on 22..16, a low line asserts
   task automatic ext_write(input logic [6:0] we, input logic [6:0] lvl, input logic data_cyc);
      logic [CIC_AD_W-1:0] word;
      word = {9'h000, we, 9'h000, lvl};
      @(posedge sys_clk);
      sys_command_bus <= 5'h08;
      sys_addr_data_bus <= word; // enables present but must be ignored here
      sys_data_valid_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      sys_command_bus <= {data_cyc, 4'h0};
      sys_addr_data_bus <= word;
      repeat (4) @(posedge sys_clk);
      sys_data_valid_n <= 1'b1;
      sys_command_bus <= 5'h00;
      // released lines float: show the inverse, not the last value
      sys_addr_data_bus <= ~word;
      repeat (4) @(posedge sys_clk);
   endtask : ext_write
endmodule : cic_sys_agent

// File: verif/test_cpu_interrupt_collector.sv
// self-checking bench for the cpu interrupt collector
// assumes one apb access cycle and pin changes reaching logic within four clocks
module test_cpu_interrupt_collector
   import cic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, nmi_pin_n, timer_irq, timer_source_select, pipe_advance;
   logic [CIC_INT_PINS-1:0] ext_int_n;
   logic [CIC_APB_AW-1:0] paddr;
   logic psel, penable, pwrite, pready, pslverr, cpu_int_req, nmi_redirect, irq;
   logic [CIC_AD_W-1:0] pwdata, prdata, sad;
   logic [CIC_CMD_W-1:0] scmd;
   logic svalid_n;
   int error_cnt, checks, redirects;

   cic_collector u_cic_collector (.sys_clk(sys_clk), .rst(rst), .nmi_pin_n(nmi_pin_n),
      .ext_int_n(ext_int_n), .timer_irq(timer_irq), .timer_source_select(timer_source_select),
      .sys_addr_data_bus(sad), .sys_command_bus(scmd), .sys_data_valid_n(svalid_n),
      .pipe_advance(pipe_advance), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_int_req(cpu_int_req), .nmi_redirect(nmi_redirect), .irq(irq));
   cic_sys_agent u_cic_sys_agent (.sys_clk(sys_clk), .sys_addr_data_bus(sad),
      .sys_command_bus(scmd), .sys_data_valid_n(svalid_n));

   ////////////////////////////////////////////////////////////////////////////
   // clock and redirect pulse counter
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (nmi_redirect === 1'b1) redirects++;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   // one apb transfer; a clock passes after release so psel is never set twice at once
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check(what, q, exp);
   endtask : rd_chk

   ////////////////////////////////////////////////////////////////////////////
   // reset values and an unmapped address
   task automatic t_reset;
      logic [31:0] q;
      logic e;
      rd_chk("status", CIC_OFS_STATUS, 32'h0);
      rd_chk("ireg", CIC_OFS_IREG, 32'h0);
      rd_chk("cause", CIC_OFS_CAUSE, 32'h0);
      check("req", {31'h0, cpu_int_req}, 32'h0);
      apb(1'b1, 12'h018, 32'hFFFF_FFFF, q, e);
      check("unmapped err", {31'h0, e}, 32'h1);
   endtask : t_reset

   // each pin to its pending bit, then the bit 15 source choice
   task automatic t_pins;
      for (int i = 0; i < CIC_INT_PINS; i++) begin
         ext_int_n <= ~(6'h01 << i);
         tick(8);
         rd_chk("cause pin", CIC_OFS_CAUSE, 32'h1 << (10 + i));
      end
      timer_source_select <= 1'b0;
      tick(8);
      rd_chk("pin5 off", CIC_OFS_CAUSE, 32'h0);
      timer_irq <= 1'b1;
      tick(8);
      rd_chk("timer", CIC_OFS_CAUSE, 32'h8000);
      timer_source_select <= 1'b1;
      ext_int_n <= 6'h3F;
      tick(8);
      rd_chk("timer off", CIC_OFS_CAUSE, 32'h0);
      timer_irq <= 1'b0;
   endtask : t_pins

   // bus-written interrupts, subset writes, address cycles ignored, event interrupt
   task automatic t_buswr;
      wr(CIC_OFS_EVT, 32'h7);
      wr(CIC_OFS_EVT_MASK, 32'h4);
      rd_chk("evt mask", CIC_OFS_EVT_MASK, 32'h4);
      u_cic_sys_agent.ext_write(7'h1F, 7'h00, 1'b0);
      tick(8);
      rd_chk("addr ignored", CIC_OFS_IREG, 32'h0);
      check("no irq", {31'h0, irq}, 32'h0);
      u_cic_sys_agent.ext_write(7'h1F, 7'h60, 1'b1);
      tick(8);
      rd_chk("ireg set", CIC_OFS_IREG, 32'h1F);
      rd_chk("cause ireg", CIC_OFS_CAUSE, 32'h7C00);
      check("irq", {31'h0, irq}, 32'h1);
      u_cic_sys_agent.ext_write(7'h05, 7'h7F, 1'b1);
      ext_int_n <= 6'h3E;
      tick(8);
      rd_chk("ireg subset", CIC_OFS_IREG, 32'h1A);
      rd_chk("cause or", CIC_OFS_CAUSE, 32'h6C00);
      // masking hides a standing event; clearing removes it
      wr(CIC_OFS_EVT_MASK, 32'h0);
      tick(3);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd_chk("evt", CIC_OFS_EVT, 32'h4);
      wr(CIC_OFS_EVT, 32'h4);
      rd_chk("evt clr", CIC_OFS_EVT, 32'h0);
      ext_int_n <= 6'h3F;
      u_cic_sys_agent.ext_write(7'h1F, 7'h7F, 1'b1);
      tick(8);
      rd_chk("ireg clr", CIC_OFS_IREG, 32'h0);
   endtask : t_buswr

   // software bits, masks, global enable and the level bits
   task automatic t_mask;
      logic [31:0] st [6] = '{32'h0101, 32'h0103, 32'h0105, 32'h0100, 32'hFE01, 32'h0101};
      logic [5:0] ex = 6'h21;
      wr(CIC_OFS_EVT, 32'h7);
      wr(CIC_OFS_CAUSE, 32'h0000_FD00);
      rd_chk("sw bits", CIC_OFS_CAUSE, 32'h0100);
      for (int i = 0; i < 6; i++) begin
         wr(CIC_OFS_STATUS, st[i]);
         tick(3);
         check("req table", {31'h0, cpu_int_req}, {31'h0, ex[i]});
      end
      ext_int_n <= 6'h37;
      wr(CIC_OFS_STATUS, 32'h2001);
      tick(8);
      check("req pin", {31'h0, cpu_int_req}, 32'h1);
      rd_chk("cause mix", CIC_OFS_CAUSE, 32'h2100);
      rd_chk("evt rose", CIC_OFS_EVT, 32'h2);
      rd_chk("status rd", CIC_OFS_STATUS, 32'h2001);
      ext_int_n <= 6'h3F;
      wr(CIC_OFS_STATUS, 32'h0);
      wr(CIC_OFS_CAUSE, 32'h0);
   endtask : t_mask

   // non-maskable path: stalled pipeline, pin, bus bit 6, all masks off
   task automatic t_nmi;
      int n0;
      n0 = redirects;
      wr(CIC_OFS_EVT, 32'h7);
      pipe_advance <= 1'b0;
      nmi_pin_n <= 1'b0;
      tick(10);
      check("stalled", redirects - n0, 32'h0);
      rd_chk("live", CIC_OFS_LIVE, 32'h1);
      pipe_advance <= 1'b1;
      tick(8);
      check("redirect", redirects - n0, 32'h1);
      nmi_pin_n <= 1'b1;
      tick(8);
      u_cic_sys_agent.ext_write(7'h40, 7'h00, 1'b1);
      tick(8);
      check("bus nmi", redirects - n0, 32'h2);
      rd_chk("ireg6", CIC_OFS_IREG, 32'h40);
      rd_chk("evt nmi", CIC_OFS_EVT, 32'h5);
      u_cic_sys_agent.ext_write(7'h40, 7'h40, 1'b1);
      tick(8);
      rd_chk("live off", CIC_OFS_LIVE, 32'h0);
   endtask : t_nmi

   task automatic summarize;
      if (error_cnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////
   // main sequence: idle pins, three-cycle reset, scenarios
   initial begin
      {sys_clk, psel, penable, pwrite, timer_irq} = 5'h00;
      {rst, nmi_pin_n, timer_source_select, pipe_advance} = 4'hF;
      ext_int_n = 6'h3F;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_pins();
      t_buswr();
      t_mask();
      t_nmi();
      summarize();
   end

   // watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
endmodule : test_cpu_interrupt_collector
